// ---- verilog/motor_start_sequencer.sv ----
// Motor start sequence state machine with APB configuration
// Behaviour
// RULE1: Wait in power-on until parameters are loaded before driving.
// RULE2: Reference zero holds sleep/standby; mode select picks sleep or standby.
// RULE3: Nonzero reference leaves sleep and checks spin-detect enable.
// RULE4: Spin detect enabled runs standstill test, else brake-enable decision.
// RULE5: Back-EMF under standstill or tach limit means stationary, else direction.
// RULE6: Forward spin goes to resync check, reverse spin to reverse drive check.
// RULE7: Resync enabled tests back-EMF floor, else coast decision.
// RULE8: Back-EMF above resync floor loads speed/position, enters closed loop.
// RULE9: Second standstill test: high back-EMF coasts, low goes to standstill brake check.
// RULE10: Coast timeout counts PWM cycles, exits on low back-EMF or 200000 cycles.
// RULE11: Standstill brake enabled runs it, else motor start-up.
// RULE12: Standstill brake turns on three low sides for its duration.
// RULE13: Reverse drive enabled checks reverse speed, else coast decision.
// RULE14: Stay reverse closed-loop decel while speed above minimum-duty speed.
// RULE15: Open-loop decel to zero, flip direction, open-loop accelerate.
// RULE16: Coast enabled runs coast routine, else brake decision.
// RULE17: Coast turns all six transistors off for coast duration.
// RULE18: Brake enabled runs brake routine, else motor start-up.
// RULE19: Brake turns on high or low sides per side select for duration.
// RULE20: Closed loop commutates by zero-cross or back-EMF integration.
// RULE21: Start-up method: align, double align, position detect, slow cycle.
// RULE22: Spin detection senses phase voltages for speed, position, direction.
// RULE23: Estimates are registered inputs; each decision takes one clock.
module motor_start_sequencer (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] speed_reference,
   input wire logic [15:0] pwm_period,
   input wire logic [9:0] bemf_level,
   input wire logic [15:0] spin_speed,
   input wire logic [2:0] spin_position,
   input wire logic spin_reverse,
   input wire logic [15:0] min_duty_speed,
   input wire logic command_reverse,
   input wire logic zero_cross_mode,
   input wire logic startup_done,
   output logic [5:0] gate_pattern,
   output logic gate_override,
   output logic sleep_request,
   output logic standby_request,
   output logic spin_detect_start,
   output logic startup_start,
   output logic [1:0] startup_method,
   output logic open_loop_start,
   output logic closed_loop_run,
   output logic commutation_zero_cross,
   output logic resync_load,
   output logic [15:0] resync_speed,
   output logic [2:0] resync_position,
   output logic drive_reverse,
   output logic reverse_closed_decel,
   output logic reverse_open_decel
);
   start_seq_pkg::seq_state_t state;
   start_seq_pkg::seq_state_t next_state;
   logic [31:0] ctrl;
   logic [31:0] times;
   logic [31:0] limits;
   logic [31:0] status;
   logic tick;
   logic [17:0] pwm_count;
   logic [15:0] ref_q;
   logic [9:0] bemf_q;
   logic [15:0] speed_q;
   logic [2:0] pos_q;
   logic rev_q;
   logic ref_nonzero;
   logic below_still;
   logic below_tach;
   logic above_resync;
   logic timed_state;
   logic [17:0] duration;
   logic timer_done;
   logic spin_enable;
   logic resync_enable;
   logic standstill_brake_enable;
   logic reverse_drive_enable;
   logic coast_enable;
   logic brake_enable;
   logic brake_side_select;
   logic sleep_standby_select;
   logic load_done;
   logic [1:0] startup_method_select;
   logic [7:0] coast_duration;
   logic [7:0] brake_duration;
   logic [7:0] standstill_brake_duration;
   logic [9:0] standstill_bemf_limit;
   logic [9:0] tach_bemf_limit;
   logic [9:0] resync_bemf_floor;
   start_seq_pkg::run_phase_t run_phase;
   logic [5:0] next_gate;

   apb_regs regs (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .status(status),
      .ctrl(ctrl),
      .times(times),
      .limits(limits)
   );

   pwm_tick divider (
      .pclk(pclk),
      .presetn(presetn),
      .period(pwm_period),
      .tick(tick)
   );

   // Configuration fields
   assign spin_enable = ctrl[start_seq_pkg::SPIN_DETECT_BIT];
   assign resync_enable = ctrl[start_seq_pkg::RESYNC_BIT];
   assign standstill_brake_enable = ctrl[start_seq_pkg::STANDSTILL_BRAKE_BIT];
   assign reverse_drive_enable = ctrl[start_seq_pkg::REVERSE_BIT];
   assign coast_enable = ctrl[start_seq_pkg::COAST_BIT];
   assign brake_enable = ctrl[start_seq_pkg::BRAKE_BIT];
   assign brake_side_select = ctrl[start_seq_pkg::BRAKE_SIDE_BIT];
   assign sleep_standby_select = ctrl[start_seq_pkg::SLEEP_SEL_BIT];
   assign load_done = ctrl[start_seq_pkg::LOAD_DONE_BIT];
   assign startup_method_select = ctrl[start_seq_pkg::STARTUP_LSB +: 2];
   assign coast_duration = times[start_seq_pkg::COAST_LSB +: 8];
   assign brake_duration = times[start_seq_pkg::BRAKE_LSB +: 8];
   assign standstill_brake_duration = times[start_seq_pkg::SBRAKE_LSB +: 8];
   assign standstill_bemf_limit = limits[start_seq_pkg::STANDSTILL_LSB +: 10];
   assign tach_bemf_limit = limits[start_seq_pkg::TACH_LSB +: 10];
   assign resync_bemf_floor = limits[start_seq_pkg::RESYNC_LSB +: 10];

   // Estimates are taken into local flops so every decision sees one sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_q <= 16'h0000;
         bemf_q <= 10'h000;
         speed_q <= 16'h0000;
         pos_q <= 3'h0;
         rev_q <= 1'b0;
      end else begin
         ref_q <= speed_reference; // RULE23
         bemf_q <= bemf_level; // RULE22
         speed_q <= spin_speed;
         pos_q <= spin_position;
         rev_q <= spin_reverse;
      end
   end

   // Threshold comparisons
   assign ref_nonzero = (ref_q != 16'h0000);
   assign below_still = (bemf_q < standstill_bemf_limit);
   assign below_tach = (bemf_q < tach_bemf_limit);
   assign above_resync = (bemf_q > resync_bemf_floor);

   // Duration of the current timed state in PWM cycles
   assign timed_state = (state == start_seq_pkg::S_COAST_TMO) ||
      (state == start_seq_pkg::S_SBRAKE) || (state == start_seq_pkg::S_COAST) ||
      (state == start_seq_pkg::S_BRAKE);
   assign duration = (state == start_seq_pkg::S_COAST_TMO) ? start_seq_pkg::COAST_TIMEOUT :
      (state == start_seq_pkg::S_SBRAKE) ? {10'h000, standstill_brake_duration} :
      (state == start_seq_pkg::S_COAST) ? {10'h000, coast_duration} :
      {10'h000, brake_duration};
   assign timer_done = tick && (pwm_count >= duration - 18'h00001);

   // PWM cycle counter, cleared on every state change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_count <= 18'h00000;
      end else if (next_state != state || !timed_state) begin
         pwm_count <= 18'h00000;
      end else if (tick) begin
         pwm_count <= pwm_count + 18'h00001; // RULE10
      end
   end

   // Next-state decisions, one clock each
   always_comb begin
      next_state = state;
      unique case (state)
         start_seq_pkg::S_POWER_ON: begin
            if (load_done) next_state = start_seq_pkg::S_SLEEP; // RULE1
         end
         start_seq_pkg::S_SLEEP: begin
            if (ref_nonzero) next_state = start_seq_pkg::S_SPIN_EN; // RULE3
         end
         start_seq_pkg::S_SPIN_EN: begin
            next_state = spin_enable ? start_seq_pkg::S_STILL1 :
               start_seq_pkg::S_BRAKE; // RULE4
            if (!spin_enable && !brake_enable) next_state = start_seq_pkg::S_RUN;
         end
         start_seq_pkg::S_STILL1: begin
            next_state = (below_still || below_tach) ? start_seq_pkg::S_STILL2 :
               start_seq_pkg::S_DIR; // RULE5
         end
         start_seq_pkg::S_DIR: begin
            next_state = (rev_q != command_reverse) ? start_seq_pkg::S_REV_CL :
               start_seq_pkg::S_RESYNC_ENABLE; // RULE6
            if (rev_q != command_reverse && !reverse_drive_enable) begin
               next_state = coast_enable ? start_seq_pkg::S_COAST :
                  brake_enable ? start_seq_pkg::S_BRAKE : start_seq_pkg::S_RUN; // RULE13
            end
         end
         start_seq_pkg::S_RESYNC_ENABLE: begin
            if (resync_enable) begin
               next_state = start_seq_pkg::S_RESYNC_THR; // RULE7
            end else begin
               next_state = coast_enable ? start_seq_pkg::S_COAST :
                  brake_enable ? start_seq_pkg::S_BRAKE : start_seq_pkg::S_RUN; // RULE16
            end
         end
         start_seq_pkg::S_RESYNC_THR: begin
            next_state = above_resync ? start_seq_pkg::S_RUN :
               start_seq_pkg::S_STILL2; // RULE8
         end
         start_seq_pkg::S_STILL2: begin
            next_state = below_still ? start_seq_pkg::S_SBRAKE_EN :
               start_seq_pkg::S_COAST_TMO; // RULE9
         end
         start_seq_pkg::S_COAST_TMO: begin
            if (below_still || timer_done) next_state = start_seq_pkg::S_SBRAKE_EN; // RULE10
         end
         start_seq_pkg::S_SBRAKE_EN: begin
            next_state = standstill_brake_enable ? start_seq_pkg::S_SBRAKE :
               start_seq_pkg::S_RUN; // RULE11
         end
         start_seq_pkg::S_SBRAKE: begin
            if (timer_done) next_state = start_seq_pkg::S_RUN; // RULE12
         end
         start_seq_pkg::S_REV_CL: begin
            if (speed_q < min_duty_speed) next_state = start_seq_pkg::S_REV_OL; // RULE14
         end
         start_seq_pkg::S_REV_OL: begin
            if (speed_q == 16'h0000) next_state = start_seq_pkg::S_RUN; // RULE15
         end
         start_seq_pkg::S_COAST: begin
            if (timer_done) begin
               next_state = brake_enable ? start_seq_pkg::S_BRAKE :
                  start_seq_pkg::S_RUN; // RULE18
            end
         end
         start_seq_pkg::S_BRAKE: begin
            if (timer_done) next_state = start_seq_pkg::S_RUN;
         end
         start_seq_pkg::S_RUN: begin
            if (!ref_nonzero) next_state = start_seq_pkg::S_SLEEP; // RULE2
         end
         default: next_state = start_seq_pkg::S_POWER_ON;
      endcase
   end

   // Gate override pattern for the timed routines
   assign next_gate = (next_state == start_seq_pkg::S_SBRAKE) ? start_seq_pkg::GATE_LOW :
      (next_state == start_seq_pkg::S_BRAKE) ?
      (brake_side_select ? start_seq_pkg::GATE_HIGH : start_seq_pkg::GATE_LOW) :
      start_seq_pkg::GATE_OFF;

   // State, gate and handoff flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= start_seq_pkg::S_POWER_ON;
         gate_pattern <= start_seq_pkg::GATE_OFF;
         gate_override <= 1'b1;
      end else begin
         state <= next_state;
         gate_pattern <= next_gate; // RULE12 RULE17 RULE19
         gate_override <= (next_state != start_seq_pkg::S_RUN) &&
            (next_state != start_seq_pkg::S_REV_CL) && (next_state != start_seq_pkg::S_REV_OL);
      end
   end

   // Run phase: resync jumps straight to closed loop, reverse decel to open loop, others through start-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_phase <= start_seq_pkg::R_NONE;
         resync_load <= 1'b0;
         resync_speed <= 16'h0000;
         resync_position <= 3'h0;
         startup_start <= 1'b0;
         open_loop_start <= 1'b0;
         drive_reverse <= 1'b0;
      end else begin
         resync_load <= 1'b0;
         startup_start <= 1'b0;
         open_loop_start <= 1'b0;
         if (state == start_seq_pkg::S_RESYNC_THR && next_state == start_seq_pkg::S_RUN) begin
            resync_load <= 1'b1; // RULE8
            resync_speed <= speed_q;
            resync_position <= pos_q;
            run_phase <= start_seq_pkg::R_CLOSED_LOOP;
         end else if (state == start_seq_pkg::S_REV_OL && next_state == start_seq_pkg::S_RUN) begin
            drive_reverse <= command_reverse; // RULE15
            open_loop_start <= 1'b1;
            run_phase <= start_seq_pkg::R_OPEN_LOOP;
         end else if (state != start_seq_pkg::S_RUN && next_state == start_seq_pkg::S_RUN) begin
            drive_reverse <= command_reverse;
            startup_start <= 1'b1; // RULE21
            run_phase <= start_seq_pkg::R_STARTUP;
         end else if (state == start_seq_pkg::S_RUN && run_phase != start_seq_pkg::R_CLOSED_LOOP
               && startup_done) begin
            run_phase <= start_seq_pkg::R_CLOSED_LOOP;
         end else if (next_state == start_seq_pkg::S_REV_CL && state == start_seq_pkg::S_DIR) begin
            drive_reverse <= rev_q; // Synchronise with reverse spin
         end
         if (next_state == start_seq_pkg::S_SLEEP) run_phase <= start_seq_pkg::R_NONE;
      end
   end

   // Handoff outputs
   assign startup_method = startup_method_select; // RULE21
   assign closed_loop_run = (state == start_seq_pkg::S_RUN) &&
      (run_phase == start_seq_pkg::R_CLOSED_LOOP); // RULE20
   assign commutation_zero_cross = zero_cross_mode; // RULE20
   assign sleep_request = (state == start_seq_pkg::S_SLEEP) && !sleep_standby_select; // RULE2
   assign standby_request = (state == start_seq_pkg::S_SLEEP) && sleep_standby_select;
   assign spin_detect_start = (state == start_seq_pkg::S_SPIN_EN) && spin_enable;
   assign reverse_closed_decel = (state == start_seq_pkg::S_REV_CL); // RULE14
   assign reverse_open_decel = (state == start_seq_pkg::S_REV_OL);
   assign status = {12'h000, run_phase, pwm_count[1:0], state};

   // Assertions
   a_power_wait: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      (state == start_seq_pkg::S_POWER_ON && !load_done) |=> state == start_seq_pkg::S_POWER_ON)
      else $error("left power-on before load");
   a_sleep_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (state == start_seq_pkg::S_SLEEP && !ref_nonzero) |=> state == start_seq_pkg::S_SLEEP)
      else $error("left sleep with zero reference");
   a_spin_branch: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (state == start_seq_pkg::S_SPIN_EN && spin_enable) |=> state == start_seq_pkg::S_STILL1)
      else $error("spin detect not entered");
   a_still_test: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      (state == start_seq_pkg::S_STILL1 && !below_still && !below_tach)
      |=> state == start_seq_pkg::S_DIR)
      else $error("spinning motor not sent to direction");
   a_resync_load: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      (state == start_seq_pkg::S_RESYNC_THR && above_resync)
      |=> resync_load && resync_speed == $past(speed_q) && closed_loop_run)
      else $error("resync handoff wrong");
   a_coast_limit: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
      state == start_seq_pkg::S_COAST_TMO |-> pwm_count < start_seq_pkg::COAST_TIMEOUT)
      else $error("coast timeout overrun");
   a_sbrake_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
      state == start_seq_pkg::S_SBRAKE |-> gate_pattern == start_seq_pkg::GATE_LOW)
      else $error("standstill brake gates wrong");
   a_coast_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
      state == start_seq_pkg::S_COAST |-> gate_pattern == start_seq_pkg::GATE_OFF && gate_override)
      else $error("coast gates not off");
   a_brake_side: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      (state == start_seq_pkg::S_BRAKE && $stable(brake_side_select) && brake_side_select)
      |-> gate_pattern == start_seq_pkg::GATE_HIGH)
      else $error("brake side wrong");
endmodule

// ---- verilog/start_seq_pkg.sv ----
// Shared constants for the motor start sequencer
package start_seq_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] TIME_OFFSET = 8'h04;
   localparam logic [7:0] LIMIT_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET = 8'h0C;
   // Control register fields
   localparam int SPIN_DETECT_BIT = 0;
   localparam int RESYNC_BIT = 1;
   localparam int STANDSTILL_BRAKE_BIT = 2;
   localparam int REVERSE_BIT = 3;
   localparam int COAST_BIT = 4;
   localparam int BRAKE_BIT = 5;
   localparam int BRAKE_SIDE_BIT = 6;
   localparam int SLEEP_SEL_BIT = 7;
   localparam int STARTUP_LSB = 8;
   localparam int LOAD_DONE_BIT = 10;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   // Time register: three 8-bit durations in units of PWM cycles
   localparam int COAST_LSB = 0;
   localparam int BRAKE_LSB = 8;
   localparam int SBRAKE_LSB = 16;
   localparam logic [31:0] TIME_RESET = 32'h0010_1010;
   // Limit register: three 10-bit back-EMF thresholds
   localparam int STANDSTILL_LSB = 0;
   localparam int TACH_LSB = 10;
   localparam int RESYNC_LSB = 20;
   localparam logic [31:0] LIMIT_RESET = 32'h0640_0805;
   // Coast timeout in PWM cycles
   localparam logic [17:0] COAST_TIMEOUT = 18'h30D40;
   // Startup methods
   localparam logic [1:0] SU_ALIGN = 2'h0;
   localparam logic [1:0] SU_DOUBLE = 2'h1;
   localparam logic [1:0] SU_IPD = 2'h2;
   localparam logic [1:0] SU_SLOW = 2'h3;
   // Gate patterns {hs_c,hs_b,hs_a,ls_c,ls_b,ls_a}
   localparam logic [5:0] GATE_OFF = 6'h00;
   localparam logic [5:0] GATE_LOW = 6'h07;
   localparam logic [5:0] GATE_HIGH = 6'h38;
   // Sequencer states, one-hot
   typedef enum logic [15:0] {
      S_POWER_ON = 16'h0001,
      S_SLEEP = 16'h0002,
      S_SPIN_EN = 16'h0004,
      S_STILL1 = 16'h0008,
      S_DIR = 16'h0010,
      S_RESYNC_ENABLE = 16'h0020,
      S_RESYNC_THR = 16'h0040,
      S_STILL2 = 16'h0080,
      S_COAST_TMO = 16'h0100,
      S_SBRAKE_EN = 16'h0200,
      S_SBRAKE = 16'h0400,
      S_REV_CL = 16'h0800,
      S_REV_OL = 16'h1000,
      S_COAST = 16'h2000,
      S_BRAKE = 16'h4000,
      S_RUN = 16'h8000
   } seq_state_t;
   // Run sub-phase reported in status
   typedef enum logic [1:0] {
      R_NONE = 2'h0,
      R_STARTUP = 2'h1,
      R_OPEN_LOOP = 2'h2,
      R_CLOSED_LOOP = 2'h3
   } run_phase_t;
endpackage

// ---- verilog/pwm_tick.sv ----
// Output PWM period divider giving a one-cycle tick
module pwm_tick (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [15:0] period,
   output logic tick
);
   logic [15:0] count;
   assign tick = (count == 16'h0000);
   // Reload at terminal count; a zero period ticks every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
      end else if (tick) begin
         count <= period;
      end else begin
         count <= count - 16'h0001;
      end
   end
endmodule

// ---- verilog/apb_regs.sv ----
// APB slave holding the sequencer configuration and status
module apb_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [31:0] status,
   output logic [31:0] ctrl,
   output logic [31:0] times,
   output logic [31:0] limits
);
   logic hit_ctrl;
   logic hit_time;
   logic hit_limit;
   logic hit_status;
   logic mapped;
   logic wr;
   // Address decode
   assign hit_ctrl = (paddr == start_seq_pkg::CTRL_OFFSET);
   assign hit_time = (paddr == start_seq_pkg::TIME_OFFSET);
   assign hit_limit = (paddr == start_seq_pkg::LIMIT_OFFSET);
   assign hit_status = (paddr == start_seq_pkg::STATUS_OFFSET);
   assign mapped = hit_ctrl | hit_time | hit_limit | hit_status;
   assign wr = psel & penable & pwrite;
   // Zero wait states; unmapped access errors
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = hit_ctrl ? ctrl : hit_time ? times : hit_limit ? limits :
      hit_status ? status : 32'h0000_0000;
   // Writable configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= start_seq_pkg::CTRL_RESET;
         times <= start_seq_pkg::TIME_RESET;
         limits <= start_seq_pkg::LIMIT_RESET;
      end else if (wr) begin
         if (hit_ctrl) ctrl <= pwdata;
         if (hit_time) times <= pwdata;
         if (hit_limit) limits <= pwdata;
      end
   end
endmodule

// ---- bench/motor_estimate_model.sv ----
// Behavioural motor and spin estimator feeding the sequencer
module motor_estimate_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [5:0] gate_pattern,
   input wire logic [9:0] bemf_set,
   input wire logic [15:0] spd_set,
   input wire logic rev_set,
   output logic [9:0] bemf_level,
   output logic [15:0] spin_speed,
   output logic [2:0] spin_position,
   output logic spin_reverse
);
   timeunit 1ns;
   timeprecision 1ps;
   // Registered estimates; a low-side brake bleeds the back-EMF away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bemf_level <= 10'h000;
         spin_speed <= 16'h0000;
         spin_position <= 3'h0;
         spin_reverse <= 1'b0;
      end else begin
         bemf_level <= (gate_pattern == start_seq_pkg::GATE_LOW) ? 10'h000 : bemf_set;
         spin_speed <= spd_set;
         spin_position <= spin_position + {2'h0, |bemf_set};
         spin_reverse <= rev_set;
      end
   end
endmodule

// ---- bench/motor_start_sequencer_bench.sv ----
// Self-checking bench for the motor start sequencer
module motor_start_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [32:0] exp_q[$];
   logic [15:0] speed_reference = 16'h0, spin_speed, resync_speed, spd_set = 16'h0, rnd = 16'h003C;
   logic [9:0] bemf_level, bemf_set = 10'h000;
   logic [2:0] spin_position;
   logic [5:0] gate_pattern, last_gate = 6'h00;
   logic spin_reverse, rev_set = 0, resync_load;
   logic [31:0] ctl[4] = '{32'h0000_0460, 32'h0000_0405, 32'h0000_0403, 32'h0000_0421};
   logic [9:0] bm[4] = '{10'h000, 10'h000, 10'h200, 10'h200};
   logic rv[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [5:0] gx[4] = '{6'h38, 6'h07, 6'h00, 6'h07};
   int error_cnt = 0, comparisons = 0, cycles = 0;
   motor_start_sequencer motor_start_sequencer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .speed_reference(speed_reference),
      .pwm_period(16'h0000), .bemf_level(bemf_level), .spin_speed(spin_speed),
      .spin_position(spin_position), .spin_reverse(spin_reverse), .min_duty_speed(16'h0100),
      .command_reverse(1'b0), .zero_cross_mode(1'b1), .startup_done(1'b0),
      .gate_pattern(gate_pattern), .gate_override(), .sleep_request(), .standby_request(),
      .spin_detect_start(), .startup_start(), .startup_method(), .open_loop_start(),
      .closed_loop_run(), .commutation_zero_cross(), .resync_load(resync_load),
      .resync_speed(resync_speed), .resync_position(), .drive_reverse(),
      .reverse_closed_decel(), .reverse_open_decel());
   motor_estimate_model motor_estimate_model_i (.pclk(pclk), .presetn(presetn),
      .gate_pattern(gate_pattern), .bemf_set(bemf_set), .spd_set(spd_set), .rev_set(rev_set),
      .bemf_level(bemf_level), .spin_speed(spin_speed), .spin_position(spin_position),
      .spin_reverse(spin_reverse));
   // Free-running core clock
   initial begin
      forever #5 pclk = ~pclk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      comparisons++;
      if (seen !== want) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic summarize();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // One APB transfer; the release is followed by an idle edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [32:0] d);
      int n;
      n = 0;
      if (!wr) exp_q.push_back(d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d[31:0];
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   function automatic logic [32:0] nxt();
      return exp_q.size() > 0 ? exp_q.pop_front() : 'x;
   endfunction
   // Watcher: read data, resync handoff and new gate patterns, plus the hang limit
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      last_gate <= gate_pattern;
      if (psel && penable && pready && !pwrite) check({pslverr, prdata}, nxt());
      if (resync_load === 1'b1) check({17'h0, resync_speed}, nxt());
      if (gate_pattern !== last_gate && gate_pattern !== 6'h00) check({27'h0, gate_pattern}, nxt());
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // Register defaults, an unmapped access, then one start path per table row
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, start_seq_pkg::CTRL_OFFSET, {1'b0, start_seq_pkg::CTRL_RESET});
      apb(1'b0, start_seq_pkg::TIME_OFFSET, {1'b0, start_seq_pkg::TIME_RESET});
      apb(1'b0, start_seq_pkg::LIMIT_OFFSET, {1'b0, start_seq_pkg::LIMIT_RESET});
      apb(1'b1, 8'h20, 33'h0_DEAD_BEEF);
      apb(1'b0, 8'h20, {1'b1, 32'h0});
      for (int i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         apb(1'b1, start_seq_pkg::CTRL_OFFSET, {1'b0, ctl[i]});
         bemf_set <= bm[i];
         rev_set <= rv[i];
         spd_set <= rnd;
         exp_q.push_back(i == 2 ? {17'h0, rnd} : {27'h0, gx[i]});
         speed_reference <= rnd | 16'h0001;
         repeat (300) @(posedge pclk);
         speed_reference <= 16'h0000;
         repeat (40) @(posedge pclk);
      end
      check({32'h0, exp_q.size() == 0}, 33'h1);
      summarize();
   end
endmodule
